//--- common/shic_pkg.sv
// Types for the standby halt and deep idle controller.
package shic_pkg;
	typedef enum logic [1:0] {
		SHIC_NORMAL    = 2'h0,
		SHIC_HALT      = 2'h1,
		SHIC_DEEP_IDLE = 2'h2 // One bit away from normal, as halt is.
	} shic_state_type;
endpackage

//--- common/shic_regs.svh
// Constants for the standby halt and deep idle controller.
`ifndef SHIC_REGS_SVH
`define SHIC_REGS_SVH
`define SHIC_MODE_DEEP_IDLE 2'h0
`define SHIC_NUM_EXT_IRQ    8
`define SHIC_NUM_PERIPH     8
`define SHIC_CNT_SEL_SUB    2'h1
`define SHIC_CNT_SEL_BAUD   2'h2
`endif

//--- design/shic_clk_gate.sv
// Glitch-free latch-based clock gate used for the CPU and peripheral clocks.
`timescale 1ns/1ps
module shic_clk_gate (
	input  wire logic clk_i,
	input  wire logic en_i,
	output logic      gclk_o
);
	logic en_lat;

	// The enable is only allowed to change while the clock is low.
	always_latch begin
		if (!clk_i) begin
			en_lat <= en_i;
		end
	end

	assign gclk_o = clk_i & en_lat;
endmodule

//--- design/shic_standby_ctrl.sv
// Standby controller for halt mode and deep idle mode.
`timescale 1ns/1ps
`include "shic_regs.svh"
// Summary of operation
// - Halt without subclock: M timer and watchdog run unless counting on subclock input.
// - Halt without subclock: watch timer runs only when counting on baud divider clock.
// - Halt leaves checksum circuit clocked but no new input is written.
// - Port outputs and CPU registers hold their values throughout halt.
// - Deep idle entered when mode select is 00 and standby trigger is written 1.
// - Deep idle keeps oscillator, PLL, flash running; CPU and peripheral clocks gated.
// - Deep idle keeps subclock or externally clocked peripherals running.
// - Deep idle keeps RAM contents and stops program execution.
// - Leaving deep idle returns to normal at once, no stabilization wait.
// - Deep idle request with unmasked interrupt pending is ignored; execution continues.
// - Deep idle released by NMI, watchdog NMI, unmasked pins or running peripheral.
// - Deep idle released by reset pin, watchdog reset, low voltage or clock monitor.
// - After any release the controller returns to normal operation.
// - Halt instruction in normal mode gates only the CPU clock.
// - Halt with unmasked interrupt pending enters halt and leaves it immediately.
// - Sources disabled by the power save control masks never release deep idle.
// - Maskable wake with interrupts disabled releases standby without acknowledge.
module shic_standby_ctrl (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          halt_exec_i,
	input  wire logic                          mode_sel_hi_i,
	input  wire logic                          mode_sel_lo_i,
	input  wire logic                          standby_trigger_i,
	input  wire logic                          nonmask_src0_block_i,
	input  wire logic                          nonmask_src2_block_i,
	input  wire logic                          ext_irq_block_i,
	input  wire logic                          nmi_pin_i,
	input  wire logic                          watchdog_nmi_req_i,
	input  wire logic [`SHIC_NUM_EXT_IRQ-1:0]  ext_irq_pins_i,
	input  wire logic [`SHIC_NUM_EXT_IRQ-1:0]  ext_irq_mask_i,
	input  wire logic [`SHIC_NUM_PERIPH-1:0]   periph_irq_i,
	input  wire logic [`SHIC_NUM_PERIPH-1:0]   periph_irq_mask_i,
	input  wire logic [`SHIC_NUM_PERIPH-1:0]   periph_sub_clk_i,
	input  wire logic                          irq_pending_i,
	input  wire logic                          int_enable_i,
	input  wire logic                          reset_pin_i,
	input  wire logic                          watchdog_reset_req_i,
	input  wire logic                          low_voltage_detect_i,
	input  wire logic                          clock_monitor_i,
	input  wire logic                          sub_clk_used_i,
	input  wire logic [1:0]                    timer_m_clk_sel_i,
	input  wire logic [1:0]                    watchdog_clk_sel_i,
	input  wire logic [1:0]                    watch_clk_sel_i,
	output logic                               cpu_clk_o,
	output logic                               periph_clk_o,
	output logic                               cpu_clk_en_o,
	output logic                               periph_clk_en_o,
	output logic                               timer_m_unit_en_o,
	output logic                               watchdog_en_o,
	output logic                               watch_timer_en_o,
	output logic [`SHIC_NUM_PERIPH-1:0]        periph_run_o,
	output logic                               checksum_wr_en_o,
	output logic                               state_hold_o,
	output logic                               osc_pll_flash_en_o,
	output logic                               halt_mode_o,
	output logic                               deep_idle_mode_o,
	output logic                               wake_no_ack_o,
	output logic                               entry_refused_o,
	output logic                               reset_wake_o
);
	typedef struct packed {
		shic_pkg::shic_state_type          state;
		logic                              cpu_en;
		logic                              per_en;
		logic                              tmm_en;
		logic                              wdt_en;
		logic                              wt_en;
		logic [`SHIC_NUM_PERIPH-1:0]       per_run;
		logic                              crc_wr;
		logic                              hold;
		logic                              halt;
		logic                              idle;
		logic                              no_ack;
		logic                              refused;
		logic                              rst_wake;
		logic                              osc;
	} shic_regs_type;

	shic_regs_type r;
	shic_regs_type nxt;
	logic          nmi_wake;
	logic          mask_wake;
	logic          rst_wake;
	logic          any_wake;
	logic [`SHIC_NUM_PERIPH-1:0] per_hit;
	logic [`SHIC_NUM_EXT_IRQ-1:0] ext_hit;

	// Per-source wake terms; masked sources never count.
	genvar g;
	generate
		for (g = 0; g < `SHIC_NUM_EXT_IRQ; g++) begin : g_ext
			assign ext_hit[g] = ext_irq_pins_i[g] & ~ext_irq_mask_i[g];
			assign per_hit[g] = periph_irq_i[g] & ~periph_irq_mask_i[g] & periph_sub_clk_i[g];
		end
	endgenerate

	// Wake sources after the power save control disables.
	assign nmi_wake  = (nmi_pin_i & ~nonmask_src0_block_i) | (watchdog_nmi_req_i & ~nonmask_src2_block_i);
	assign mask_wake = ~ext_irq_block_i & ((|ext_hit) | (|per_hit));
	assign rst_wake  = reset_pin_i | watchdog_reset_req_i | low_voltage_detect_i | clock_monitor_i;
	assign any_wake  = nmi_wake | mask_wake | rst_wake;

	// Next state and next output values.
	always_comb begin
		nxt          = r;
		nxt.no_ack   = 1'b0;
		nxt.refused  = 1'b0;
		nxt.rst_wake = 1'b0;
		case (r.state)
			shic_pkg::SHIC_NORMAL: begin
				if (standby_trigger_i && {mode_sel_hi_i, mode_sel_lo_i} == `SHIC_MODE_DEEP_IDLE) begin
					if (irq_pending_i || any_wake) begin
						nxt.refused = 1'b1;
					end else begin
						nxt.state = shic_pkg::SHIC_DEEP_IDLE;
					end
				end else if (halt_exec_i) begin
					nxt.state = shic_pkg::SHIC_HALT;
				end
			end
			shic_pkg::SHIC_HALT: begin
				if (any_wake || irq_pending_i) begin
					nxt.state    = shic_pkg::SHIC_NORMAL;
					nxt.no_ack   = ~int_enable_i & ~nmi_wake & ~rst_wake;
					nxt.rst_wake = rst_wake;
				end
			end
			shic_pkg::SHIC_DEEP_IDLE: begin
				if (any_wake) begin
					nxt.state    = shic_pkg::SHIC_NORMAL;
					nxt.no_ack   = ~int_enable_i & ~nmi_wake & ~rst_wake;
					nxt.rst_wake = rst_wake;
				end
			end
			default: begin
				nxt.state = shic_pkg::SHIC_NORMAL;
			end
		endcase
		nxt.halt   = (nxt.state == shic_pkg::SHIC_HALT);
		nxt.idle   = (nxt.state == shic_pkg::SHIC_DEEP_IDLE);
		nxt.cpu_en = (nxt.state == shic_pkg::SHIC_NORMAL);
		nxt.per_en = ~nxt.idle;
		nxt.hold   = ~nxt.cpu_en;
		nxt.crc_wr = nxt.cpu_en;
		// Timers on the subclock stop in halt only when no subclock is present.
		nxt.tmm_en = nxt.idle ? sub_clk_used_i :
			(~nxt.halt | sub_clk_used_i | (timer_m_clk_sel_i != `SHIC_CNT_SEL_SUB));
		nxt.wdt_en = nxt.idle ? sub_clk_used_i :
			(~nxt.halt | sub_clk_used_i | (watchdog_clk_sel_i != `SHIC_CNT_SEL_SUB));
		nxt.wt_en  = nxt.idle ? sub_clk_used_i :
			(~nxt.halt | sub_clk_used_i | (watch_clk_sel_i == `SHIC_CNT_SEL_BAUD));
		nxt.per_run = nxt.idle ? periph_sub_clk_i : {`SHIC_NUM_PERIPH{1'b1}};
		nxt.osc     = 1'b1; // Oscillator, PLL and flash are never stopped here.
	end

	// State register, reset into normal operation.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			r          <= '0;
			r.cpu_en   <= 1'b1;
			r.per_en   <= 1'b1;
			r.tmm_en   <= 1'b1;
			r.wdt_en   <= 1'b1;
			r.wt_en    <= 1'b1;
			r.per_run  <= {`SHIC_NUM_PERIPH{1'b1}};
			r.crc_wr   <= 1'b1;
			r.osc      <= 1'b1;
		end else begin
			r <= nxt;
		end
	end

	// Glitch-free gates for the CPU and peripheral clock trees.
	shic_clk_gate u_cpu_gate (
		.clk_i  (clk_i),
		.en_i   (r.cpu_en),
		.gclk_o (cpu_clk_o)
	);
	shic_clk_gate u_per_gate (
		.clk_i  (clk_i),
		.en_i   (r.per_en),
		.gclk_o (periph_clk_o)
	);

	// Registered status and enables.
	assign cpu_clk_en_o       = r.cpu_en;
	assign periph_clk_en_o    = r.per_en;
	assign timer_m_unit_en_o  = r.tmm_en;
	assign watchdog_en_o      = r.wdt_en;
	assign watch_timer_en_o   = r.wt_en;
	assign periph_run_o       = r.per_run;
	assign checksum_wr_en_o   = r.crc_wr;
	assign state_hold_o       = r.hold;
	assign osc_pll_flash_en_o = r.osc;
	assign halt_mode_o        = r.halt;
	assign deep_idle_mode_o   = r.idle;
	assign wake_no_ack_o      = r.no_ack;
	assign entry_refused_o    = r.refused;
	assign reset_wake_o       = r.rst_wake;
endmodule

//--- tb/shic_chk.sv
// Checker for the standby controller ports.
`timescale 1ns/1ps
module shic_chk (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       halt_exec_i,
	input wire logic       standby_trigger_i,
	input wire logic       mode_sel_hi_i,
	input wire logic       mode_sel_lo_i,
	input wire logic       irq_pending_i,
	input wire logic       ext_irq_block_i,
	input wire logic [7:0] ext_irq_pins_i,
	input wire logic [7:0] ext_irq_mask_i,
	input wire logic       reset_pin_i,
	input wire logic       halt_mode_o,
	input wire logic       deep_idle_mode_o,
	input wire logic       cpu_clk_en_o,
	input wire logic       periph_clk_en_o,
	input wire logic       osc_pll_flash_en_o,
	input wire logic       state_hold_o,
	input wire logic       entry_refused_o,
	input wire logic       reset_wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Normal state and a deep idle request, decoded once for the properties.
	wire nrm = !halt_mode_o && !deep_idle_mode_o;
	wire idle_req = standby_trigger_i && !mode_sel_hi_i && !mode_sel_lo_i;
	halt_entry_a: assert property (nrm && halt_exec_i && !standby_trigger_i |=> halt_mode_o && !cpu_clk_en_o
		&& periph_clk_en_o) else $error("halt entry wrong");
	idle_refuse_a: assert property (nrm && idle_req && irq_pending_i |=> !deep_idle_mode_o && entry_refused_o)
		else $error("idle entry not refused");
	idle_gate_a: assert property (deep_idle_mode_o |-> !cpu_clk_en_o && !periph_clk_en_o && osc_pll_flash_en_o)
		else $error("idle clocks wrong");
	halt_hold_a: assert property (halt_mode_o |-> state_hold_o) else $error("halt state not held");
	halt_pend_a: assert property (halt_mode_o && irq_pending_i |=> nrm && cpu_clk_en_o) else $error("halt stuck");
	idle_wake_a: assert property (deep_idle_mode_o && !ext_irq_block_i && |(ext_irq_pins_i & ~ext_irq_mask_i)
		|=> nrm && periph_clk_en_o) else $error("pin wake missed");
	reset_wake_a: assert property (deep_idle_mode_o && reset_pin_i |=> nrm && reset_wake_o)
		else $error("reset wake missed");
	idle_cause_a: assert property ($rose(deep_idle_mode_o) |-> $past(idle_req) && !$past(irq_pending_i))
		else $error("idle entered without request");
	cover property (nrm ##1 halt_mode_o);
	cover property (nrm ##1 deep_idle_mode_o);
	cover property (entry_refused_o);
endmodule
bind shic_standby_ctrl shic_chk shic_chk_inst (.*);

//--- tb/shic_cpu_model.sv
// CPU core model that issues halt and standby instruction pulses.
`timescale 1ns/1ps
module shic_cpu_model (
	input  wire logic clk_i,
	output logic      halt_exec_o,
	output logic      standby_trigger_o
);
	initial {halt_exec_o, standby_trigger_o} = 2'h0;
	// One instruction pulse, raised and dropped only at falling edges.
	task automatic issue(input logic idle);
		@(negedge clk_i);
		halt_exec_o = !idle;
		standby_trigger_o = idle;
		@(negedge clk_i);
		{halt_exec_o, standby_trigger_o} = 2'h0;
	endtask
	// Software follows a standby request with five idle no-op cycles.
	task automatic nops();
		repeat (5) @(negedge clk_i);
	endtask
endmodule

//--- tb/tb_top.sv
// Testbench for the standby halt and deep idle controller.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'h0, rst_i = 1'h1, mode_sel_hi_i = 1'h1, mode_sel_lo_i = 1'h0, ext_irq_block_i = 1'h0;
	logic nonmask_src0_block_i = 1'h0, nonmask_src2_block_i = 1'h0, irq_pending_i = 1'h0, int_enable_i = 1'h1;
	logic sub_clk_used_i = 1'h0, cpu_clk_o, periph_clk_o, cpu_clk_en_o, periph_clk_en_o, timer_m_unit_en_o;
	logic [7:0] ext_irq_pins_i = 8'h00, ext_irq_mask_i = 8'hFE, periph_irq_mask_i = 8'h00, periph_sub_clk_i = 8'h01;
	logic [1:0] timer_m_clk_sel_i = 2'h1, watchdog_clk_sel_i = 2'h2, watch_clk_sel_i = 2'h2;
	logic [6:0] wk = 7'h00;
	logic nmi_pin_i, watchdog_nmi_req_i, reset_pin_i, watchdog_reset_req_i, low_voltage_detect_i, clock_monitor_i;
	logic halt_exec_i, standby_trigger_i, watchdog_en_o, watch_timer_en_o, checksum_wr_en_o, state_hold_o;
	logic osc_pll_flash_en_o, halt_mode_o, deep_idle_mode_o, wake_no_ack_o, entry_refused_o, reset_wake_o;
	logic [7:0] periph_irq_i, periph_run_o;
	int mismatches = 0, checks = 0;
	// Wake and reset sources come from one vector so a loop can step through them.
	assign {nmi_pin_i, watchdog_nmi_req_i, reset_pin_i, watchdog_reset_req_i, low_voltage_detect_i} = wk[5:1];
	assign clock_monitor_i = wk[0];
	assign periph_irq_i = {7'h00, wk[6]};
	shic_standby_ctrl shic_standby_ctrl_inst (.*);
	shic_cpu_model cpu (.clk_i(clk_i), .halt_exec_o(halt_exec_i), .standby_trigger_o(standby_trigger_i));
	initial forever #2 clk_i = ~clk_i;
	// Compares one result and counts it.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Samples the gated clocks just after a rising edge, then returns on the next falling edge.
	task automatic chk_clks(input logic [1:0] exp);
		@(posedge clk_i);
		#1;
		chk({6'h00, cpu_clk_o, periph_clk_o}, {6'h00, exp});
		@(negedge clk_i);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic print_verdict();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Halt gates only the CPU clock; a pin wake with interrupts off is not acknowledged.
	task automatic t_halt();
		cpu.issue(1'h0);
		chk({halt_mode_o, cpu_clk_en_o, periph_clk_en_o, state_hold_o, checksum_wr_en_o}, 8'h16);
		chk({timer_m_unit_en_o, watchdog_en_o, watch_timer_en_o}, 8'h03);
		chk_clks(2'h1);
		sub_clk_used_i = 1'h1;
		@(negedge clk_i);
		chk({timer_m_unit_en_o, watchdog_en_o, watch_timer_en_o}, 8'h07);
		int_enable_i = 1'h0;
		ext_irq_pins_i = 8'h01;
		@(negedge clk_i);
		chk({halt_mode_o, cpu_clk_en_o, wake_no_ack_o}, 8'h03);
		{int_enable_i, sub_clk_used_i, ext_irq_pins_i} = 10'h200;
	endtask
	// Deep idle gates the CPU and peripheral clocks, ignores blocked sources and wakes on every other source.
	task automatic t_idle();
		mode_sel_hi_i = 1'h0;
		cpu.issue(1'h1);
		cpu.nops();
		chk({deep_idle_mode_o, cpu_clk_en_o, periph_clk_en_o, osc_pll_flash_en_o}, 8'h09);
		chk(periph_run_o, 8'h01);
		chk({timer_m_unit_en_o, watchdog_en_o, watch_timer_en_o}, 8'h00);
		chk_clks(2'h0);
		{ext_irq_block_i, nonmask_src0_block_i, nonmask_src2_block_i, irq_pending_i} = 4'hF;
		ext_irq_pins_i = 8'h03;
		wk = 7'h30;
		repeat (3) @(negedge clk_i);
		chk({7'h00, deep_idle_mode_o}, 8'h01);
		ext_irq_block_i = 1'h0;
		@(negedge clk_i);
		chk({deep_idle_mode_o, cpu_clk_en_o, wake_no_ack_o}, 8'h02);
		{nonmask_src0_block_i, nonmask_src2_block_i, irq_pending_i, ext_irq_pins_i, wk} = 18'h0;
		chk_clks(2'h3);
		for (int i = 0; i < 7; i++) begin
			cpu.issue(1'h1);
			wk = 7'h01 << i;
			@(negedge clk_i);
			chk({deep_idle_mode_o, cpu_clk_en_o, reset_wake_o}, {6'h00, 1'h1, i < 4});
			wk = 7'h00;
		end
	endtask
	// A pending interrupt refuses deep idle, and makes halt last a single cycle.
	task automatic t_refuse();
		irq_pending_i = 1'h1;
		cpu.issue(1'h1);
		chk({deep_idle_mode_o, entry_refused_o}, 8'h01);
		mode_sel_hi_i = 1'h1;
		cpu.issue(1'h0);
		chk({7'h00, halt_mode_o}, 8'h01);
		@(negedge clk_i);
		chk({7'h00, halt_mode_o}, 8'h00);
		irq_pending_i = 1'h0;
	endtask
	// A reset in mid-run leaves deep idle at once and restarts in normal operation.
	task automatic t_reset();
		mode_sel_hi_i = 1'h0;
		cpu.issue(1'h1);
		chk({7'h00, deep_idle_mode_o}, 8'h01);
		rst_i = 1'h1;
		#1;
		chk({deep_idle_mode_o, halt_mode_o, cpu_clk_en_o, periph_clk_en_o}, 8'h03);
		@(negedge clk_i);
		rst_i = 1'h0;
		mode_sel_hi_i = 1'h1;
		repeat (2) @(negedge clk_i);
		chk({deep_idle_mode_o, halt_mode_o, cpu_clk_en_o, periph_clk_en_o}, 8'h03);
	endtask
	// Main sequence after six cycles of reset.
	initial begin
		repeat (6) @(posedge clk_i);
		@(negedge clk_i) rst_i = 1'h0;
		t_halt();
		t_idle();
		t_refuse();
		t_reset();
		print_verdict();
	end
	// Cuts a hang short well after the tests should have ended.
	initial begin
		#2000;
		mismatches++;
		print_verdict();
	end
endmodule
